// *** ceasu_core.sv ***
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Contract
// - flag load from memory uses a word read
// - flag store to memory uses a word write
// - and/or/xor immediate into flag or extended control register
// - no-operation only advances program counter by 2
// - byte-count block move: skip on zero, else copy bytes until zero
// - word-count block move: same, with the 16-bit count
// - next instruction may start right after the last block byte
// - instructions are 2-byte units with op, register, extension, cond
// - leading four bits are operation field; some carry a second one
// - address register select 3 bits, data register 3 or 4 bits
// - 8/16/32-bit extensions; 24-bit values held with top byte 00
// - top eight address bits dropped, memory sees 16 bits
// - eight addressing modes, each instruction its own subset
// - arith: register direct/immediate; transfer: not pc-rel/mem-ind
// - bit ops: direct/indirect/absolute; register bit number limited
// - register direct picks byte halves, word halves or long registers
// - register indirect uses low 24 bits of address register
// - displacement added, 16-bit sign-extended, low 24 bits used
// - post-increment adds 1, 2 or 4 to full register afterwards
// - trap starts exception handling, return resumes flow
// - sleep enters power-down state
// - branch condition taken from the condition field
// - pre-decrement subtracts 1, 2 or 4 and uses the result
// - 8-bit absolute upper bits ones, 16-bit sign-extended
// - pc-relative displacement sign-extended, added to next pc
// - memory indirect reads a longword, first byte ignored
module ceasu_core import ceasu_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // memory and peripheral bus master
  output logic [15:0] memAddr,
  output logic memRead,
  output logic memWrite,
  output logic memWide,
  output logic [15:0] memWdata,
  input wire logic [15:0] memRdata,
  input wire logic memAck,
  // cpu events
  output logic trapStart,
  output logic [1:0] trapVector,
  output logic excReturn,
  output logic powerDown
);
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_LOADF, ST_STOREF,
    ST_MRD, ST_MWR, ST_IND_HI, ST_IND_LO} ceasu_state_e;

  logic [1:0] rstPipe_q;
  logic rstN;
  ceasu_state_e state_q;
  logic [15:0] instr_q;
  logic [31:0] ext_q;
  logic [23:0] pc_q;
  logic [7:0] condFlag_q;
  logic [7:0] extCtrl_q;
  logic [31:0] regs_q [0:7];
  logic [2:0] regSel_q;
  logic [15:0] ea_q;
  logic [31:0] operand_q;
  logic illegal_q;
  logic [7:0] moveByte_q;
  logic [7:0] indHi_q;
  logic [31:0] readdata_q;
  logic waitrequest_q;
  logic [15:0] memAddr_q;
  logic memRead_q;
  logic memWrite_q;
  logic memWide_q;
  logic [15:0] memWdata_q;
  logic trapStart_q;
  logic [1:0] trapVector_q;
  logic excReturn_q;
  logic powerDown_q;

  // reset release through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstN = rstPipe_q[1];

  // instruction fields
  logic [3:0] opField, subOp, cond, rSel;
  logic [2:0] aReg, bitKind;
  ceasu_mode_e mode;
  logic [1:0] size, absW;
  logic varBit, flagSel;
  assign opField = instr_q[15:12];
  assign subOp = instr_q[11:8];
  assign cond = instr_q[11:8];
  assign mode = ceasu_mode_e'(instr_q[11:9]);
  assign size = instr_q[8:7];
  assign rSel = instr_q[6:3];
  assign aReg = instr_q[5:3];
  assign bitKind = instr_q[8:6];
  assign varBit = instr_q[2];
  assign absW = instr_q[1:0];
  assign flagSel = instr_q[7];

  logic isSys, isMem, isMove, moveLast, legal, bccTrue;
  logic [15:0] moveCount;
  logic [23:0] extLen, pcNext, ea24, stepVal;
  logic [31:0] aVal, regOperand, immOperand;
  logic [2:0] bitNumber;
  assign isSys = opField == OP_SYS;
  assign isMem = opField == OP_XFER || opField == OP_ARITH
    || opField == OP_BIT || opField == OP_JUMP;
  assign isMove = isSys && (subOp == SUB_MOVB || subOp == SUB_MOVW);
  assign aVal = regs_q[aReg];
  assign stepVal = size == SZ_BYTE ? 24'h000001 :
    size == SZ_WORD ? 24'h000002 : 24'h000004;
  assign bitNumber = varBit ? regs_q[ext_q[2:0]][2:0] : ext_q[2:0];
  assign moveCount = subOp == SUB_MOVW ? regs_q[BLK_CNT_REG][15:0]
    : {8'h00, regs_q[BLK_CNT_REG][7:0]};
  assign moveLast = moveCount == 16'h0001;

  // legality per instruction class
  always_comb begin
    legal = 1'b1;
    unique case (opField)
      OP_NOP, OP_BCC: legal = 1'b1;
      OP_SYS: legal = subOp <= SUB_MOVW;
      OP_XFER: legal = mode != AM_PCREL && mode != AM_MEMIND;
      OP_ARITH: legal = mode == AM_REGDIR || mode == AM_IMM;
      OP_BIT: legal = (mode == AM_REGDIR || mode == AM_REGIND
        || mode == AM_ABS) && !(varBit && bitKind > BIT_KIND_REG_MAX);
      OP_JUMP: legal = mode == AM_REGIND || mode == AM_ABS
        || mode == AM_PCREL || mode == AM_MEMIND;
      default: legal = 1'b0;
    endcase
  end

  // extension length in bytes, whole 2-byte units
  always_comb begin
    extLen = 24'h000000;
    if (isSys && (subOp == SUB_AND || subOp == SUB_OR || subOp == SUB_XOR))
      extLen = 24'h000002;
    else if (isMem) begin
      unique case (mode)
        AM_DISP: extLen = varBit ? 24'h000004 : 24'h000002;
        AM_ABS: extLen = absW > AW_16 ? 24'h000004 : 24'h000002;
        AM_IMM: extLen = size > SZ_WORD ? 24'h000004 : 24'h000002;
        AM_PCREL: extLen = 24'h000002;
        AM_MEMIND: extLen = 24'h000002;
        default: extLen = 24'h000000;
      endcase
    end
  end
  assign pcNext = pc_q + INSTR_BYTES + extLen;

  // effective address, 24 bits wide before truncation
  always_comb begin
    ea24 = aVal[23:0];
    unique case (mode)
      AM_DISP: ea24 = aVal[23:0] + (varBit ? ext_q[23:0]
        : {{8{ext_q[15]}}, ext_q[15:0]});
      AM_INCDEC: ea24 = varBit ? aVal[23:0] - stepVal : aVal[23:0];
      AM_ABS: begin
        if (absW == AW_8) ea24 = {ABS8_UPPER, ext_q[7:0]};
        else if (absW == AW_16) ea24 = {{8{ext_q[15]}}, ext_q[15:0]};
        else ea24 = ext_q[23:0];
      end
      AM_PCREL: ea24 = pcNext + (varBit
        ? {{8{ext_q[15]}}, ext_q[15:0]} : {{16{ext_q[7]}}, ext_q[7:0]});
      AM_MEMIND: ea24 = {16'h0000, ext_q[7:0]};
      default: ea24 = aVal[23:0];
    endcase
  end

  // register direct and immediate operands
  always_comb begin
    regOperand = regs_q[rSel[2:0]];
    if (size == SZ_BYTE)
      regOperand = {24'h000000, rSel[3] ? regs_q[rSel[2:0]][7:0]
        : regs_q[rSel[2:0]][15:8]};
    else if (size == SZ_WORD)
      regOperand = {16'h0000, rSel[3] ? regs_q[rSel[2:0]][31:16]
        : regs_q[rSel[2:0]][15:0]};
    immOperand = ext_q;
    if (size == SZ_BYTE) immOperand = {24'h000000, ext_q[7:0]};
    else if (size == SZ_WORD) immOperand = {16'h0000, ext_q[15:0]};
  end

  // branch conditions over c, v, z, n
  logic fc, fv, fz, fn;
  assign fc = condFlag_q[FLG_C];
  assign fv = condFlag_q[FLG_V];
  assign fz = condFlag_q[FLG_Z];
  assign fn = condFlag_q[FLG_N];
  always_comb begin
    unique case (cond[3:1])
      3'h0: bccTrue = 1'b1;
      3'h1: bccTrue = !(fc | fz);
      3'h2: bccTrue = !fc;
      3'h3: bccTrue = !fz;
      3'h4: bccTrue = !fv;
      3'h5: bccTrue = !fn;
      3'h6: bccTrue = !(fn ^ fv);
      default: bccTrue = !(fz | (fn ^ fv));
    endcase
    bccTrue = bccTrue ^ cond[0];
  end

  // bus slave; writes stall while an instruction runs
  logic canAck, taken, takeWr;
  logic [31:0] beMask;
  assign canAck = read || (write && state_q == ST_IDLE);
  assign taken = (read || write) && waitrequest_q && canAck;
  // a write lands only at the edge where waitrequest is seen low
  assign takeWr = write && !waitrequest_q;
  assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
    {8{byteenable[1]}}, {8{byteenable[0]}}};

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h00000000;
    end else begin
      waitrequest_q <= !taken;
      if (taken && read) begin
        unique case (address)
          OFS_INSTR: readdata_q <= {16'h0000, instr_q};
          OFS_EXT: readdata_q <= ext_q;
          OFS_STATUS: readdata_q <= {29'h0, powerDown_q, illegal_q,
            state_q != ST_IDLE};
          OFS_FLAGS: readdata_q <= {16'h0000, extCtrl_q, condFlag_q};
          OFS_EA: readdata_q <= {16'h0000, ea_q};
          OFS_PC: readdata_q <= {8'h00, pc_q};
          OFS_REGSEL: readdata_q <= {29'h0, regSel_q};
          OFS_REGDATA: readdata_q <= regs_q[regSel_q];
          OFS_DECODE: readdata_q <= {13'h0, bitNumber, legal, 3'h0,
            opField, subOp, rSel};
          OFS_OPERAND: readdata_q <= operand_q;
          default: readdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // sequencer and memory master
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_IDLE;
      instr_q <= 16'h0000;
      memAddr_q <= 16'h0000;
      memRead_q <= 1'b0;
      memWrite_q <= 1'b0;
      memWide_q <= 1'b0;
      memWdata_q <= 16'h0000;
      moveByte_q <= 8'h00;
      indHi_q <= 8'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: if (takeWr && address == OFS_INSTR) begin
          instr_q <= writedata[15:0];
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          state_q <= ST_IDLE;
          if (legal && isSys && subOp == SUB_LOAD) begin
            memAddr_q <= aVal[15:0];
            memRead_q <= 1'b1;
            memWide_q <= 1'b1;
            state_q <= ST_LOADF;
          end else if (legal && isSys && subOp == SUB_STORE) begin
            memAddr_q <= aVal[15:0];
            memWrite_q <= 1'b1;
            memWide_q <= 1'b1;
            memWdata_q <= flagSel ? {extCtrl_q, extCtrl_q}
              : {condFlag_q, condFlag_q};
            state_q <= ST_STOREF;
          end else if (legal && isMove && moveCount != 16'h0000) begin
            memAddr_q <= regs_q[BLK_SRC_REG][15:0];
            memRead_q <= 1'b1;
            memWide_q <= 1'b0;
            state_q <= ST_MRD;
          end else if (legal && opField == OP_JUMP && mode == AM_MEMIND) begin
            memAddr_q <= ea24[15:0];
            memRead_q <= 1'b1;
            memWide_q <= 1'b1;
            state_q <= ST_IND_HI;
          end
        end
        ST_LOADF, ST_STOREF: if (memAck) begin
          memRead_q <= 1'b0;
          memWrite_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        ST_MRD: if (memAck) begin
          moveByte_q <= memRdata[7:0];
          memRead_q <= 1'b0;
          memWrite_q <= 1'b1;
          memAddr_q <= regs_q[BLK_DST_REG][15:0];
          memWdata_q <= {8'h00, memRdata[7:0]};
          state_q <= ST_MWR;
        end
        ST_MWR: if (memAck) begin
          memWrite_q <= 1'b0;
          // last byte frees the sequencer on the same edge
          if (moveLast) begin
            state_q <= ST_IDLE;
          end else begin
            memRead_q <= 1'b1;
            memAddr_q <= regs_q[BLK_SRC_REG][15:0] + 16'h0001;
            state_q <= ST_MRD;
          end
        end
        ST_IND_HI: if (memAck) begin
          indHi_q <= memRdata[7:0];
          memAddr_q <= memAddr_q + 16'h0002;
          state_q <= ST_IND_LO;
        end
        ST_IND_LO: if (memAck) begin
          memRead_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // program counter
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pc_q <= PC_RST;
    end else if (state_q == ST_IDLE && takeWr && address == OFS_PC) begin
      pc_q <= (pc_q & ~beMask[23:0]) | (writedata[23:0] & beMask[23:0]);
    end else if (state_q == ST_EXEC) begin
      if (legal && opField == OP_JUMP && mode != AM_MEMIND)
        pc_q <= ea24;
      else if (legal && opField == OP_BCC && bccTrue)
        pc_q <= pcNext + {{16{instr_q[7]}}, instr_q[7:0]};
      else
        pc_q <= pcNext;
    end else if (state_q == ST_IND_LO && memAck) begin
      pc_q <= {indHi_q, memRdata};
    end
  end

  // flag and extended control registers
  logic [7:0] flagSrc, flagRes;
  assign flagSrc = flagSel ? extCtrl_q : condFlag_q;
  always_comb begin
    flagRes = flagSrc & ext_q[7:0];
    if (subOp == SUB_OR) flagRes = flagSrc | ext_q[7:0];
    else if (subOp == SUB_XOR) flagRes = flagSrc ^ ext_q[7:0];
  end
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      condFlag_q <= CFLAG_RST;
      extCtrl_q <= EXTC_RST;
    end else if (state_q == ST_IDLE && takeWr && address == OFS_FLAGS) begin
      if (byteenable[0]) condFlag_q <= writedata[7:0];
      if (byteenable[1]) extCtrl_q <= writedata[15:8];
    end else if (state_q == ST_EXEC && legal && isSys
        && (subOp == SUB_AND || subOp == SUB_OR || subOp == SUB_XOR)) begin
      if (flagSel) extCtrl_q <= flagRes;
      else condFlag_q <= flagRes;
    end else if (state_q == ST_LOADF && memAck) begin
      if (flagSel) extCtrl_q <= memRdata[15:8];
      else condFlag_q <= memRdata[15:8];
    end
  end

  // general registers and the extension word
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < 8; i++) regs_q[i] <= REG_RST;
      regSel_q <= 3'h0;
      ext_q <= 32'h00000000;
    end else if (state_q == ST_IDLE && takeWr) begin
      if (address == OFS_REGDATA)
        regs_q[regSel_q] <= (regs_q[regSel_q] & ~beMask)
          | (writedata & beMask);
      if (address == OFS_REGSEL && byteenable[0])
        regSel_q <= writedata[2:0];
      if (address == OFS_EXT)
        ext_q <= (ext_q & ~beMask) | (writedata & beMask);
    end else if (state_q == ST_EXEC && legal && isMem && mode == AM_INCDEC)
    begin
      if (varBit) regs_q[aReg] <= aVal - {8'h00, stepVal};
      else regs_q[aReg] <= aVal + {8'h00, stepVal};
    end else if (state_q == ST_MWR && memAck) begin
      regs_q[BLK_SRC_REG] <= regs_q[BLK_SRC_REG] + 32'h00000001;
      regs_q[BLK_DST_REG] <= regs_q[BLK_DST_REG] + 32'h00000001;
      if (subOp == SUB_MOVW)
        regs_q[BLK_CNT_REG][15:0] <= moveCount - 16'h0001;
      else
        regs_q[BLK_CNT_REG][7:0] <= moveCount[7:0] - 8'h01;
    end
  end

  // address result, operand, status and cpu events
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ea_q <= 16'h0000;
      operand_q <= 32'h00000000;
      illegal_q <= 1'b0;
      trapStart_q <= 1'b0;
      trapVector_q <= 2'h0;
      excReturn_q <= 1'b0;
      powerDown_q <= 1'b0;
    end else begin
      trapStart_q <= state_q == ST_EXEC && legal && isSys
        && subOp == SUB_TRAP;
      excReturn_q <= state_q == ST_EXEC && legal && isSys
        && subOp == SUB_RETURN;
      if (state_q == ST_EXEC && isSys && subOp == SUB_TRAP)
        trapVector_q <= ext_q[1:0];
      if (state_q == ST_EXEC && legal && isMem) begin
        ea_q <= ea24[15:0];
        operand_q <= mode == AM_IMM ? immOperand : regOperand;
      end
      // set wins over a software clear
      if (state_q == ST_EXEC && !legal)
        illegal_q <= 1'b1;
      else if (takeWr && address == OFS_STATUS && writedata[ST_ILLEGAL_BIT])
        illegal_q <= 1'b0;
      if (state_q == ST_EXEC && legal && isSys && subOp == SUB_SLEEP)
        powerDown_q <= 1'b1;
      else if (takeWr && address == OFS_STATUS && writedata[ST_PDOWN_BIT])
        powerDown_q <= 1'b0;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign memAddr = memAddr_q;
  assign memRead = memRead_q;
  assign memWrite = memWrite_q;
  assign memWide = memWide_q;
  assign memWdata = memWdata_q;
  assign trapStart = trapStart_q;
  assign trapVector = trapVector_q;
  assign excReturn = excReturn_q;
  assign powerDown = powerDown_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstN);

  nop_pc_step_a: assert property (state_q == ST_EXEC
    && opField == OP_NOP |=> pc_q == $past(pc_q) + 24'h000002)
    else $error("nop pc step wrong");
  flag_load_word_a: assert property (state_q == ST_LOADF
    |-> memRead_q && memWide_q) else $error("flag load not word read");
  flag_store_word_a: assert property (state_q == ST_STOREF
    |-> memWrite_q && memWide_q) else $error("flag store not word write");
  flag_and_a: assert property (state_q == ST_EXEC && legal && isSys
    && subOp == SUB_AND && !flagSel
    |=> condFlag_q == ($past(condFlag_q) & $past(ext_q[7:0])))
    else $error("flag and result wrong");
  move_skip_a: assert property (state_q == ST_EXEC && isMove
    && moveCount == 16'h0000 |=> state_q == ST_IDLE && !memRead_q)
    else $error("zero count move not skipped");
  move_done_a: assert property (state_q == ST_MWR && memAck && moveLast
    |=> state_q == ST_IDLE ##1 !waitrequest_q || state_q == ST_IDLE)
    else $error("move end not immediate");
  move_byte_a: assert property (state_q == ST_MWR && memAck
    |=> $past(moveCount) - 16'h0001 == moveCount || state_q == ST_IDLE)
    else $error("move count not decremented");
  abs8_upper_a: assert property (state_q == ST_EXEC && isMem
    && mode == AM_ABS && absW == AW_8 |=> ea_q[15:8] == 8'hff || !$past(legal))
    else $error("short absolute upper bits wrong");
  post_inc_a: assert property (state_q == ST_EXEC && legal && isMem
    && mode == AM_INCDEC && !varBit
    |=> regs_q[$past(aReg)] == $past(aVal) + {8'h00, $past(stepVal)})
    else $error("post increment wrong");
endmodule : ceasu_core

// *** ceasu_pkg.sv ***
package ceasu_pkg;
  // byte offsets on the register bus
  localparam logic [5:0] OFS_INSTR = 6'h00;
  localparam logic [5:0] OFS_EXT = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_FLAGS = 6'h0c;
  localparam logic [5:0] OFS_EA = 6'h10;
  localparam logic [5:0] OFS_PC = 6'h14;
  localparam logic [5:0] OFS_REGSEL = 6'h18;
  localparam logic [5:0] OFS_REGDATA = 6'h1c;
  localparam logic [5:0] OFS_DECODE = 6'h20;
  localparam logic [5:0] OFS_OPERAND = 6'h24;
  // status bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ILLEGAL_BIT = 1;
  localparam int ST_PDOWN_BIT = 2;
  // condition flag bits
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  // reset values
  localparam logic [7:0] CFLAG_RST = 8'h00;
  localparam logic [7:0] EXTC_RST = 8'h00;
  localparam logic [23:0] PC_RST = 24'h000000;
  localparam logic [31:0] REG_RST = 32'h00000000;
  // operation field values
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_SYS = 4'h1;
  localparam logic [3:0] OP_XFER = 4'h2;
  localparam logic [3:0] OP_BCC = 4'h3;
  localparam logic [3:0] OP_ARITH = 4'h4;
  localparam logic [3:0] OP_BIT = 4'h5;
  localparam logic [3:0] OP_JUMP = 4'h6;
  // system sub-operations (second operation field)
  localparam logic [3:0] SUB_TRAP = 4'h0;
  localparam logic [3:0] SUB_RETURN = 4'h1;
  localparam logic [3:0] SUB_SLEEP = 4'h2;
  localparam logic [3:0] SUB_AND = 4'h3;
  localparam logic [3:0] SUB_OR = 4'h4;
  localparam logic [3:0] SUB_XOR = 4'h5;
  localparam logic [3:0] SUB_LOAD = 4'h6;
  localparam logic [3:0] SUB_STORE = 4'h7;
  localparam logic [3:0] SUB_MOVB = 4'h8;
  localparam logic [3:0] SUB_MOVW = 4'h9;
  typedef enum logic [2:0] {AM_REGDIR, AM_REGIND, AM_DISP, AM_INCDEC,
    AM_ABS, AM_IMM, AM_PCREL, AM_MEMIND} ceasu_mode_e;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] AW_8 = 2'h0;
  localparam logic [1:0] AW_16 = 2'h1;
  localparam logic [2:0] BLK_CNT_REG = 3'h4;
  localparam logic [2:0] BLK_SRC_REG = 3'h5;
  localparam logic [2:0] BLK_DST_REG = 3'h6;
  localparam logic [2:0] BIT_KIND_REG_MAX = 3'h3;
  localparam logic [15:0] ABS8_UPPER = 16'hffff;
  localparam logic [23:0] INSTR_BYTES = 24'h000002;
endpackage : ceasu_pkg

// *** ceasu_mem_model.sv ***
`timescale 1ns/1ps
module ceasu_mem_model (
  // clock
  input wire logic mclk,
  // memory bus from the core
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic memWide,
  input wire logic [15:0] memWdata,
  output logic [15:0] memRdata,
  output logic memAck,
  // answer delay in cycles
  input wire logic [3:0] lat
);
  logic [7:0] mem [256];
  logic [3:0] cnt;
  logic [7:0] a0;
  logic [7:0] a1;
  assign a0 = memAddr[7:0];
  assign a1 = a0 + 8'h01;
  initial begin
    memAck = 1'b0;
    cnt = 4'h0;
    memRdata = 16'h0000;
  end
  // read data outside an answer toggles so stale values never match
  always @(posedge mclk) begin
    if (memAck) begin
      memAck <= 1'b0;
      cnt <= 4'h0;
      memRdata <= ~memRdata;
      if (memWrite && memWide) begin
        mem[a0] <= memWdata[15:8];
        mem[a1] <= memWdata[7:0];
      end else if (memWrite) begin
        mem[a0] <= memWdata[7:0];
      end
    end else if ((memRead || memWrite) && cnt >= lat) begin
      memAck <= 1'b1;
      memRdata <= memWide ? {mem[a0], mem[a1]} : {~mem[a0], mem[a0]};
    end else begin
      cnt <= (memRead || memWrite) ? cnt + 4'h1 : 4'h0;
      memRdata <= ~memRdata;
    end
  end
endmodule : ceasu_mem_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb import ceasu_pkg::*;;
  logic mclk, nrst, read, write, waitrequest, memRead, memWrite, memWide;
  logic memAck, trapStart, excReturn, powerDown, lastWide;
  logic [5:0] address;
  logic [3:0] byteenable, lat;
  logic [31:0] writedata, readdata, rd;
  logic [15:0] memAddr, memWdata, memRdata;
  logic [1:0] trapVector;
  int errors, tests_run, cycles, accCnt, trapCnt, retCnt;
  ceasu_core u_ceasu_core (.mclk, .nrst, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest, .memAddr, .memRead,
    .memWrite, .memWide, .memWdata, .memRdata, .memAck, .trapStart,
    .trapVector, .excReturn, .powerDown);
  ceasu_mem_model u_ceasu_mem_model (.mclk, .memAddr, .memRead, .memWrite,
    .memWide, .memWdata, .memRdata, .memAck, .lat);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (memAck) begin
      accCnt++;
      lastWide <= memWide;
    end
    if (trapStart === 1'b1) trapCnt++;
    if (excReturn === 1'b1) retCnt++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [5:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic exec(input logic [15:0] ins, input logic [31:0] ext);
    bus(1'b1, OFS_EXT, ext);
    bus(1'b1, OFS_INSTR, {16'h0000, ins});
    do begin
      bus(1'b0, OFS_STATUS, 32'h0);
    end while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask : exec
  task automatic setReg(input logic [2:0] r, input logic [31:0] v);
    bus(1'b1, OFS_REGSEL, {29'h0, r});
    bus(1'b1, OFS_REGDATA, v);
  endtask : setReg
  task automatic getReg(input logic [2:0] r);
    bus(1'b1, OFS_REGSEL, {29'h0, r});
    bus(1'b0, OFS_REGDATA, 32'h0);
  endtask : getReg
  task automatic tNop;
    logic [31:0] pc, fl;
    bus(1'b0, OFS_PC, 32'h0);
    pc = rd;
    bus(1'b0, OFS_FLAGS, 32'h0);
    fl = rd;
    exec({OP_NOP, 12'h000}, 32'h0);
    bus(1'b0, OFS_PC, 32'h0);
    chk("pc", rd & 32'hffffff, (pc + 32'h2) & 32'hffffff);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags", rd, fl);
  endtask : tNop
  task automatic tFlags;
    exec({OP_SYS, SUB_OR, 8'h00}, 32'h0f);
    exec({OP_SYS, SUB_AND, 8'h00}, 32'h3c);
    exec({OP_SYS, SUB_XOR, 8'h00}, 32'hff);
    exec({OP_SYS, SUB_OR, 8'h80}, 32'h5a);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags", rd & 32'hffff, 32'h5af3);
  endtask : tFlags
  task automatic tFlagMem;
    setReg(3'h2, 32'h40);
    exec({OP_SYS, SUB_STORE, 8'h10}, 32'h0);
    chk("st", {u_ceasu_mem_model.mem[8'h40], u_ceasu_mem_model.mem[8'h41]},
      32'hf3f3);
    chk("stwide", lastWide, 1'b1);
    u_ceasu_mem_model.mem[8'h42] = 8'h05;
    u_ceasu_mem_model.mem[8'h43] = 8'hee;
    setReg(3'h2, 32'h42);
    exec({OP_SYS, SUB_LOAD, 8'h10}, 32'h0);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("ld", rd & 32'hff, 32'h05);
    chk("ldwide", lastWide, 1'b1);
  endtask : tFlagMem
  task automatic tMove;
    for (int i = 0; i < 3; i++) u_ceasu_mem_model.mem[8'h10 + i] = 8'ha1 + i;
    lat <= 4'h3;
    setReg(BLK_CNT_REG, 32'h103);
    setReg(BLK_SRC_REG, 32'h10);
    setReg(BLK_DST_REG, 32'h20);
    accCnt = 0;
    exec({OP_SYS, SUB_MOVB, 8'h00}, 32'h0);
    chk("acc", accCnt, 6);
    for (int i = 0; i < 3; i++)
      chk("dst", u_ceasu_mem_model.mem[8'h20 + i], 8'ha1 + i);
    getReg(BLK_CNT_REG);
    chk("cnt", rd, 32'h100);
    accCnt = 0;
    exec({OP_SYS, SUB_MOVB, 8'h00}, 32'h0);
    chk("skip", accCnt, 0);
    getReg(BLK_SRC_REG);
    chk("src", rd, 32'h13);
    lat <= 4'h0;
    accCnt = 0;
    exec({OP_SYS, SUB_MOVW, 8'h00}, 32'h0);
    chk("accw", accCnt, 512);
    getReg(BLK_CNT_REG);
    chk("cntw", rd & 32'hffff, 32'h0);
    getReg(BLK_DST_REG);
    chk("dstw", rd, 32'h123);
  endtask : tMove
  task automatic tEvents;
    exec({OP_SYS, SUB_TRAP, 8'h00}, 32'h2);
    chk("trap", trapCnt, 1);
    chk("vec", trapVector, 2'h2);
    exec({OP_SYS, SUB_RETURN, 8'h00}, 32'h0);
    chk("ret", retCnt, 1);
    exec({OP_SYS, SUB_SLEEP, 8'h00}, 32'h0);
    chk("pd", powerDown, 1'b1);
    bus(1'b1, OFS_STATUS, 32'h4);
    @(posedge mclk);
    chk("pdclr", powerDown, 1'b0);
  endtask : tEvents
  task automatic tModes;
    logic [15:0] ins [6] = '{16'h2218, 16'h2418, 16'h269c, 16'h2718,
      16'h2800, 16'h2801};
    logic [31:0] ext [6] = '{0, 32'hfffe, 0, 0, 32'h12, 32'h8001};
    logic [31:0] ea [6] = '{32'h3456, 32'h3454, 32'h3454, 32'h3454,
      32'hff12, 32'h8001};
    logic [31:0] rv [6] = '{32'h123456, 32'h123456, 32'h123454,
      32'h123458, 32'h123458, 32'h123458};
    setReg(3'h3, 32'h123456);
    for (int i = 0; i < 6; i++) begin
      exec(ins[i], ext[i]);
      bus(1'b0, OFS_EA, 32'h0);
      chk("ea", rd & 32'hffff, ea[i]);
      getReg(3'h3);
      chk("areg", rd, rv[i]);
    end
  endtask : tModes
  task automatic tJump;
    u_ceasu_mem_model.mem[8'h31] = 8'h12;
    u_ceasu_mem_model.mem[8'h32] = 8'h34;
    u_ceasu_mem_model.mem[8'h33] = 8'h56;
    exec(16'h6e00, 32'h30);
    bus(1'b0, OFS_PC, 32'h0);
    chk("ind", rd, 32'h123456);
    exec(16'h6c00, 32'hfe);
    bus(1'b0, OFS_PC, 32'h0);
    chk("rel", rd, 32'h123458);
    exec(16'h3710, 32'h0);
    bus(1'b0, OFS_PC, 32'h0);
    chk("bcct", rd, 32'h12346a);
    exec(16'h3610, 32'h0);
    bus(1'b0, OFS_PC, 32'h0);
    chk("bccf", rd, 32'h12346c);
    exec(16'h4a80, 32'h1234abcd);
    bus(1'b0, OFS_OPERAND, 32'h0);
    chk("imm", rd, 32'habcd);
    bus(1'b0, OFS_DECODE, 32'h0);
    chk("dec", rd, 32'h584a0);
    exec(16'h4058, 32'h0);
    bus(1'b0, OFS_OPERAND, 32'h0);
    chk("rdir", rd, 32'h58);
    exec(16'h4200, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("ill", rd[ST_ILLEGAL_BIT], 1'b1);
  endtask : tJump
  initial begin
    {nrst, read, write, address, byteenable, writedata, lat} = '0;
    lastWide = 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    tNop();
    tFlags();
    tFlagMem();
    tMove();
    tEvents();
    tModes();
    tJump();
    end_of_test();
  end
endmodule : tb
